// ==== rtl/charger_ctl.sv ====
// charger input-limit selection, chip disable, thermal zones, sleep and fault pulses
`timescale 1ns/1ps
`include "charger_ctl_regs.svh"

// Function
// - usb limit starts at 100 mA until detection produces a result
// - auto detection only in default mode; host mode needs the force bit
// - a host write to register 2 aborts a running detection
// - connection detect first, then wait 10 ms before primary detection
// - charger port gives 1.5 A, standard port keeps 100 mA, no secondary step
// - detection takes at least 90 ms; after 500 ms choose 100 mA
// - auto detection starts only while both data lines are below 0.6 V
// - force bit starts detection; device clears it and detaches on completion
// - host-written limit overrides detection; second input never touched
// - default mode select pin: high gives 100 mA (or 500 mA), low 1.5 A
// - after any host write the select pin is ignored until watchdog expiry
// - chip disable high stops charging and forces high impedance
// - chip disable high resets safety timer; in host mode forces high impedance
// - chip disable outranks any host enable or mode setting
// - regulator output on with a supply, off in uvlo, sleep or thermal shutdown
// - hot or cold zone suspends charging and all charge timers
// - warm zone lowers regulation target by 140 mV
// - cool zone halves the charge current
// - thermal shutdown stops charging, converter, timers; pulse and update bits
// - after shutdown, restart charging once die has cooled about 10 degrees
// - sleep: stop converter, battery fet on, gate low, pulse, update bits
// - leaving sleep clears state and fault bits and starts a new cycle
// - entering default mode reloads defaults and restarts the safety timer
module charger_ctl
   import charger_ctl_pkg::*;
#(
   parameter int        SETTLE_CYC   = `DCD_SETTLE_CYC,
   parameter int        MIN_CYC      = `DETECT_MIN_CYC,
   parameter int        MAX_CYC      = `DETECT_MAX_CYC,
   parameter int        PULSE_CYC    = `FAULT_PULSE_CYC,
   parameter bit        HIGH_SEL_500 = 1'b0
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   // analog comparator levels (asynchronous)
   input  wire logic        usb_above_uvlo_in,
   input  wire logic        in_above_uvlo_in,
   input  wire logic        supply_above_sleep_in,
   input  wire logic        dp_below_0v6_in,
   input  wire logic        dm_below_0v6_in,
   input  wire logic        data_contact_in,
   input  wire logic        port_is_charger_in,
   input  wire logic        die_over_shutdown_in,
   input  wire logic        die_cooled_in,
   input  wire logic        ntc_below_hot_in,
   input  wire logic        ntc_below_warm_in,
   input  wire logic        ntc_above_cool_in,
   input  wire logic        ntc_above_cold_in,
   // pins
   input  wire logic        chip_disable_n_in,
   input  wire logic        usb_limit_sel_in,
   // host side, same clock
   input  wire logic        host_mode_in,
   input  wire logic        host_write_in,
   input  wire logic        host_write_reg2_in,
   input  wire logic        detect_force_set_in,
   input  wire logic        host_ilim_valid_in,
   input  wire logic [15:0] host_usb_ilim_in,
   input  wire logic        host_charge_en_in,
   input  wire logic        host_hiz_in,
   input  wire logic        watchdog_expired_in,
   input  wire logic [15:0] prog_vreg_mv_in,
   input  wire logic [15:0] prog_ichg_ma_in,
   // detection and limits
   output logic             detect_force_out,
   output logic             detect_attach_out,
   output logic             detect_busy_out,
   output logic [15:0]      usb_ilim_ma_out,
   // charge control
   output logic             charge_enable_out,
   output logic             hiz_out,
   output logic             converter_enable_out,
   output logic             battery_fet_on_out,
   output logic             discharge_gate_drive_out,
   output logic             timers_suspend_out,
   output logic             safety_timer_reset_out,
   output logic             regs_reload_out,
   output logic             regulator_output_out,
   output logic [15:0]      vreg_target_mv_out,
   output logic [15:0]      ichg_target_ma_out,
   output ntc_zone_t        ntc_zone_out,
   // status
   output logic [2:0]       charge_state_bits_out,
   output logic [2:0]       fault_bits_out,
   output logic             stat_out,
   output logic             int_out
);

   // ==========================================================
   // input synchronisers
   localparam int NSYNC = 15;
   logic [NSYNC-1:0] raw;
   logic [NSYNC-1:0] syn;
   assign raw = {usb_limit_sel_in, chip_disable_n_in, ntc_above_cold_in, ntc_above_cool_in,
                 ntc_below_warm_in, ntc_below_hot_in, die_cooled_in, die_over_shutdown_in,
                 port_is_charger_in, data_contact_in, dm_below_0v6_in, dp_below_0v6_in,
                 supply_above_sleep_in, in_above_uvlo_in, usb_above_uvlo_in};

   for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      sync_bit u_sync (
         .clk_in    (clk_in),
         .arst_n_in (arst_n_in),
         .d_in      (raw[i]),
         .q_out     (syn[i])
      );
   end

   logic usb_ok, in_ok, above_sleep, dp_low, dm_low, contact, is_charger;
   logic die_hot, die_cool, below_hot, below_warm, above_cool, above_cold;
   logic dis_pin, sel_pin;
   assign {sel_pin, dis_pin, above_cold, above_cool, below_warm, below_hot, die_cool, die_hot,
           is_charger, contact, dm_low, dp_low, above_sleep, in_ok, usb_ok} = syn;

   logic any_supply;
   logic chip_off;
   assign any_supply = usb_ok | in_ok;
   // despite its low-active name the pin switches the chip off when high
   assign chip_off   = dis_pin;

   // ==========================================================
   // default mode entry tracking
   logic host_prev;
   logic usb_prev;
   logic enter_default;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         host_prev <= 1'b0;
         usb_prev  <= 1'b0;
      end else begin
         host_prev <= host_mode_in;
         usb_prev  <= usb_ok;
      end
   end
   assign enter_default   = host_prev & ~host_mode_in;
   assign regs_reload_out = enter_default;

   // ==========================================================
   // detection sequencer
   det_state_t  state;
   logic [31:0] step_cnt;
   logic [31:0] total_cnt;
   logic        found_charger;
   logic        det_result;
   logic        auto_start;
   logic        force_start;
   logic        finish;

   assign auto_start  = ~host_mode_in & usb_ok & ~usb_prev & dp_low & dm_low;
   assign force_start = detect_force_out & usb_ok;
   assign finish      = (state == DET_DONE) | (state == DET_ABORT);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state         <= DET_IDLE;
         step_cnt      <= 32'h0;
         total_cnt     <= 32'h0;
         found_charger <= 1'b0;
      end else if (host_write_reg2_in && state != DET_IDLE) begin
         state <= DET_ABORT;
      end else begin
         total_cnt <= (state == DET_IDLE) ? 32'h0 : total_cnt + 32'h1;
         case (state)
            DET_IDLE: begin
               step_cnt <= 32'h0;
               if (auto_start || force_start) begin
                  state         <= DET_CONNECT;
                  found_charger <= 1'b0;
               end
            end
            DET_CONNECT: begin
               if (contact) begin
                  state    <= DET_SETTLE;
                  step_cnt <= 32'h0;
               end
            end
            DET_SETTLE: begin
               step_cnt <= step_cnt + 32'h1;
               if (step_cnt >= 32'(SETTLE_CYC - 1)) begin
                  state <= DET_PRIMARY;
               end
            end
            DET_PRIMARY: begin
               // primary step only; a secondary step is never run
               if (total_cnt >= 32'(MIN_CYC - 1)) begin
                  found_charger <= is_charger;
                  state         <= DET_DONE;
               end
            end
            DET_DONE, DET_ABORT: begin
               state <= DET_IDLE;
            end
            default: state <= DET_IDLE;
         endcase
         // unfinished at the deadline: unknown source
         if (state != DET_IDLE && !finish && total_cnt >= 32'(MAX_CYC - 1)) begin
            found_charger <= 1'b0;
            state         <= DET_DONE;
         end
      end
   end

   assign det_result        = (state == DET_DONE);
   assign detect_busy_out   = (state != DET_IDLE) & ~finish;
   assign detect_attach_out = detect_busy_out;

   // force bit: host sets, device clears on completion; set wins
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         detect_force_out <= 1'b0;
      end else if (detect_force_set_in) begin
         detect_force_out <= 1'b1;
      end else if (finish || enter_default) begin
         detect_force_out <= 1'b0;
      end
   end

   // ==========================================================
   // usb current limit
   logic        host_owned;
   logic        pin_ignored;
   logic [15:0] det_limit;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pin_ignored <= 1'b0;
      end else if (host_write_in) begin
         pin_ignored <= 1'b1;
      end else if (watchdog_expired_in) begin
         pin_ignored <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         det_limit <= `ILIM_USB_LOW_MA;
      end else if (usb_ok && !usb_prev) begin
         det_limit <= `ILIM_USB_LOW_MA;
      end else if (det_result) begin
         det_limit <= found_charger ? `ILIM_USB_HIGH_MA : `ILIM_USB_LOW_MA;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         host_owned <= 1'b0;
      end else if (enter_default) begin
         host_owned <= 1'b0;
      end else if (host_ilim_valid_in) begin
         host_owned <= 1'b1;
      end
   end

   logic [15:0] host_limit;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         host_limit <= `ILIM_USB_LOW_MA;
      end else if (host_ilim_valid_in) begin
         host_limit <= host_usb_ilim_in;
      end
   end

   // only the usb input limit is produced here; the second input is never steered
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         usb_ilim_ma_out <= `ILIM_USB_LOW_MA;
      end else if (host_owned) begin
         usb_ilim_ma_out <= host_limit;
      end else if (!host_mode_in && !pin_ignored) begin
         usb_ilim_ma_out <= sel_pin ? (HIGH_SEL_500 ? `ILIM_USB_MID_MA : `ILIM_USB_LOW_MA)
                                    : `ILIM_USB_HIGH_MA;
      end else begin
         usb_ilim_ma_out <= det_limit;
      end
   end

   // ==========================================================
   // thermistor zones
   ntc_zone_t zone;
   always_comb begin
      if (!below_hot) begin
         zone = ZONE_HOT;
      end else if (above_cold) begin
         zone = ZONE_COLD;
      end else if (!below_warm) begin
         zone = ZONE_WARM;
      end else if (above_cool) begin
         zone = ZONE_COOL;
      end else begin
         zone = ZONE_NORMAL;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         ntc_zone_out       <= ZONE_NORMAL;
         vreg_target_mv_out <= 16'h0000;
         ichg_target_ma_out <= 16'h0000;
      end else begin
         ntc_zone_out       <= zone;
         vreg_target_mv_out <= (zone == ZONE_WARM) ? prog_vreg_mv_in - `VREG_WARM_DROP_MV
                                                   : prog_vreg_mv_in;
         ichg_target_ma_out <= (zone == ZONE_COOL) ? {1'b0, prog_ichg_ma_in[15:1]}
                                                   : prog_ichg_ma_in;
      end
   end

   // ==========================================================
   // thermal shutdown and sleep
   logic thermal_sd;
   logic sleeping;
   logic sleep_cond;
   assign sleep_cond = any_supply & ~above_sleep;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         thermal_sd <= 1'b0;
      end else if (die_hot) begin
         thermal_sd <= 1'b1;
      end else if (die_cool) begin
         thermal_sd <= 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sleeping <= 1'b0;
      end else begin
         sleeping <= sleep_cond;
      end
   end

   logic sd_entry;
   logic sleep_entry;
   logic new_cycle;
   logic off_prev;
   assign sd_entry    = die_hot & ~thermal_sd;
   assign sleep_entry = sleep_cond & ~sleeping;
   assign new_cycle   = (thermal_sd & ~die_hot & die_cool) | (sleeping & ~sleep_cond);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         charge_state_bits_out <= `STATE_NORMAL;
         fault_bits_out        <= `FAULT_NONE;
      end else if (sd_entry) begin
         charge_state_bits_out <= `STATE_THERMAL;
         fault_bits_out        <= `FAULT_THERMAL;
      end else if (sleep_entry) begin
         charge_state_bits_out <= `STATE_SLEEP;
         fault_bits_out        <= `FAULT_SLEEP;
      end else if (new_cycle) begin
         charge_state_bits_out <= `STATE_NORMAL;
         fault_bits_out        <= `FAULT_NONE;
      end
   end

   logic pulse;
   fault_pulse #(
      .PULSE_CYC (PULSE_CYC)
   ) u_pulse (
      .clk_in    (clk_in),
      .arst_n_in (arst_n_in),
      .trig_in   (sd_entry | sleep_entry),
      .pulse_out (pulse)
   );
   assign stat_out = pulse;
   assign int_out  = pulse;

   // ==========================================================
   // charge control outputs
   logic ntc_stop;
   assign ntc_stop = (zone == ZONE_HOT) | (zone == ZONE_COLD);

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         off_prev <= 1'b0;
      end else begin
         off_prev <= chip_off;
      end
   end
   // pin edge or default entry restarts the safety timer
   assign safety_timer_reset_out = (chip_off & ~off_prev) | enter_default;

   always_comb begin
      hiz_out              = chip_off | (host_mode_in & host_hiz_in);
      charge_enable_out    = ~chip_off & host_charge_en_in & ~ntc_stop & ~thermal_sd
                             & ~sleeping & any_supply;
      converter_enable_out = ~hiz_out & any_supply & ~thermal_sd & ~sleeping;
      battery_fet_on_out   = sleeping | ~converter_enable_out;
      discharge_gate_drive_out = ~sleeping & (~any_supply | hiz_out);
      timers_suspend_out   = ntc_stop | thermal_sd;
      regulator_output_out = any_supply & ~sleeping & ~thermal_sd;
   end

   // ==========================================================
   // checks
   property p_off_blocks_charge;
      @(posedge clk_in) disable iff (!arst_n_in) chip_off |-> (hiz_out && !charge_enable_out);
   endproperty
   a_off_blocks_charge : assert property (p_off_blocks_charge)
      else $error("chip disable did not stop charging");

   property p_force_clears;
      @(posedge clk_in) disable iff (!arst_n_in) (finish && !detect_force_set_in) |=> !detect_force_out;
   endproperty
   a_force_clears : assert property (p_force_clears)
      else $error("force bit not cleared after detection");

   property p_abort;
      @(posedge clk_in) disable iff (!arst_n_in) (host_write_reg2_in && detect_busy_out) |=> state == DET_ABORT;
   endproperty
   a_abort : assert property (p_abort)
      else $error("register 2 write did not abort detection");

   property p_charger_limit;
      @(posedge clk_in) disable iff (!arst_n_in) (det_result && found_charger) |=> det_limit == `ILIM_USB_HIGH_MA;
   endproperty
   a_charger_limit : assert property (p_charger_limit)
      else $error("charger port limit not raised");

   property p_ntc_suspend;
      @(posedge clk_in) disable iff (!arst_n_in) ntc_stop |-> (timers_suspend_out && !charge_enable_out);
   endproperty
   a_ntc_suspend : assert property (p_ntc_suspend)
      else $error("thermistor zone did not suspend charge");

   property p_sd_pulse;
      @(posedge clk_in) disable iff (!arst_n_in)
      (sd_entry && !pulse) |=> stat_out && int_out && charge_state_bits_out == `STATE_THERMAL;
   endproperty
   a_sd_pulse : assert property (p_sd_pulse)
      else $error("thermal shutdown pulse missing");

   property p_regulator;
      @(posedge clk_in) disable iff (!arst_n_in) (thermal_sd || !any_supply) |-> !regulator_output_out;
   endproperty
   a_regulator : assert property (p_regulator)
      else $error("regulator on in shutdown");

   property p_host_override;
      @(posedge clk_in) disable iff (!arst_n_in)
      host_owned && $stable(host_limit) |=> usb_ilim_ma_out == $past(host_limit);
   endproperty
   a_host_override : assert property (p_host_override)
      else $error("host limit not applied");

endmodule : charger_ctl

// ==== rtl/charger_ctl_pkg.sv ====
// types for the charger input-limit control block
package charger_ctl_pkg;

   // ==========================================================
   // detection sequencer states
   typedef enum logic [5:0] {
      DET_IDLE    = 6'h01,
      DET_CONNECT = 6'h02,
      DET_SETTLE  = 6'h04,
      DET_PRIMARY = 6'h08,
      DET_DONE    = 6'h10,
      DET_ABORT   = 6'h20
   } det_state_t;

   // ==========================================================
   // thermistor zones
   typedef enum logic [2:0] {
      ZONE_NORMAL = 3'h0,
      ZONE_COLD   = 3'h1,
      ZONE_COOL   = 3'h2,
      ZONE_WARM   = 3'h3,
      ZONE_HOT    = 3'h4
   } ntc_zone_t;

endpackage : charger_ctl_pkg

// ==== rtl/charger_ctl_regs.svh ====
// constants for the charger input-limit control block
`ifndef CHARGER_CTL_REGS_SVH
`define CHARGER_CTL_REGS_SVH

// ==========================================================
// timing
`define CLK_PERIOD_NS        4
`define DCD_SETTLE_MS        10
`define DETECT_MIN_MS        90
`define DETECT_MAX_MS        500
`define FAULT_PULSE_US       128
`define CYC_PER_MS           (1000000 / `CLK_PERIOD_NS)
`define DCD_SETTLE_CYC       (`DCD_SETTLE_MS * `CYC_PER_MS)
`define DETECT_MIN_CYC       (`DETECT_MIN_MS * `CYC_PER_MS)
`define DETECT_MAX_CYC       (`DETECT_MAX_MS * `CYC_PER_MS)
`define FAULT_PULSE_CYC      ((`FAULT_PULSE_US * 1000) / `CLK_PERIOD_NS)

// ==========================================================
// limit and adjustment values, in mA and mV
`define ILIM_USB_LOW_MA      16'h0064
`define ILIM_USB_MID_MA      16'h01F4
`define ILIM_USB_HIGH_MA     16'h05DC
`define VREG_WARM_DROP_MV    16'h008C

// ==========================================================
// charge state and fault bit codes
`define STATE_NORMAL         3'h0
`define STATE_SLEEP          3'h1
`define STATE_THERMAL        3'h2
`define FAULT_NONE           3'h0
`define FAULT_SLEEP          3'h1
`define FAULT_THERMAL        3'h2

`endif

// ==== rtl/fault_pulse.sv ====
// fixed-length fault pulse generator for status and interrupt
`timescale 1ns/1ps
`include "charger_ctl_regs.svh"

module fault_pulse #(
   parameter int PULSE_CYC = `FAULT_PULSE_CYC
) (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   // trigger and output
   input  wire logic trig_in,
   output logic      pulse_out
);

   logic [15:0] count;

   // retrigger ignored while running so the width stays fixed
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count     <= 16'h0000;
         pulse_out <= 1'b0;
      end else if (pulse_out) begin
         if (count == 16'(PULSE_CYC - 1)) begin
            pulse_out <= 1'b0;
            count     <= 16'h0000;
         end else begin
            count <= count + 16'h0001;
         end
      end else if (trig_in) begin
         pulse_out <= 1'b1;
         count     <= 16'h0000;
      end
   end

   property p_width_fixed;
      @(posedge clk_in) disable iff (!arst_n_in) $rose(pulse_out) |-> pulse_out [*8] ##0 (count == 16'h0007);
   endproperty
   a_width_fixed : assert property (p_width_fixed)
      else $error("fault pulse width counter misaligned");

endmodule : fault_pulse

// ==== rtl/sync_bit.sv ====
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps

module sync_bit (
   // clock and reset
   input  wire logic clk_in,
   input  wire logic arst_n_in,
   // data
   input  wire logic d_in,
   output logic      q_out
);

   logic meta;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         meta  <= 1'b0;
         q_out <= 1'b0;
      end else begin
         meta  <= d_in;
         q_out <= meta;
      end
   end

endmodule : sync_bit

// ==== verification/testbench.sv ====
// self-checking bench for the charger control block
`timescale 1ns/1ps
module testbench import charger_ctl_pkg::*;;
   logic clk_in = 0, arst_n_in = 0, usb_above_uvlo_in = 0, in_above_uvlo_in = 1, supply_above_sleep_in = 1;
   logic dp_below_0v6_in, dm_below_0v6_in, data_contact_in, port_is_charger_in, die_over_shutdown_in = 0;
   logic die_cooled_in = 0, ntc_below_hot_in = 1, ntc_below_warm_in = 1, ntc_above_cool_in = 0, ntc_above_cold_in = 0;
   logic chip_disable_n_in = 0, usb_limit_sel_in = 1, host_mode_in = 0, host_write_in = 0, host_write_reg2_in = 0;
   logic detect_force_set_in = 0, host_ilim_valid_in = 0, host_charge_en_in = 1, host_hiz_in = 0;
   logic watchdog_expired_in = 0, charger = 1, answer = 1;
   logic [15:0] host_usb_ilim_in = 16'h0000, prog_vreg_mv_in = 16'h1068, prog_ichg_ma_in = 16'h03E8;
   logic detect_force_out, detect_attach_out, detect_busy_out, charge_enable_out, hiz_out, converter_enable_out;
   logic battery_fet_on_out, discharge_gate_drive_out, timers_suspend_out, safety_timer_reset_out;
   logic regs_reload_out, regulator_output_out, stat_out, int_out;
   logic [15:0] usb_ilim_ma_out, vreg_target_mv_out, ichg_target_ma_out;
   logic [2:0]  charge_state_bits_out, fault_bits_out;
   ntc_zone_t   ntc_zone_out;
   int          fail_count = 0, comparisons = 0, n, n_rst = 0, n_reload = 0;
   // ==========================================================
   // design and port model
   charger_ctl #(.SETTLE_CYC(20), .MIN_CYC(100), .MAX_CYC(400), .PULSE_CYC(16)) dut (.*);
   usb_port_model port (.clk_in(clk_in), .attach_in(detect_attach_out), .is_charger_in(charger),
      .answer_in(answer), .contact_out(data_contact_in), .charger_out(port_is_charger_in),
      .dp_low_out(dp_below_0v6_in), .dm_low_out(dm_below_0v6_in));
   initial forever #2 clk_in = ~clk_in;
   // one-cycle pulses, counted at the edge that samples them
   always @(posedge clk_in) begin
      n_rst += safety_timer_reset_out;
      n_reload += regs_reload_out;
   end
   // ==========================================================
   // helpers
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic go(input int k);
      repeat (k) @(posedge clk_in);
   endtask : go
   // waits out a running detection, counting its cycles
   task automatic wait_idle(output int cyc);
      cyc = 0;
      // two sync edges plus the start edge before busy shows
      go(4);
      #1;
      while (detect_busy_out !== 1'b0 && cyc < 1000) begin
         go(1);
         #1;
         cyc++;
      end
   endtask : wait_idle
   task automatic pulse_len(output int cnt);
      cnt = 0;
      repeat (40) begin
         go(1);
         #1;
         cnt += (stat_out === 1'b1 && int_out === 1'b1);
      end
   endtask : pulse_len
   task automatic force_det;
      go(1);
      detect_force_set_in <= 1;
      go(1);
      detect_force_set_in <= 0;
   endtask : force_det
   task close_out;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   // ==========================================================
   // tests
   initial begin
      go(12);
      arst_n_in <= 1;
      go(4);
      #1 chk(usb_ilim_ma_out, 16'h0064);
      go(1);
      host_write_in <= 1;
      go(1);
      host_write_in <= 0;
      usb_above_uvlo_in <= 1;
      wait_idle(n);
      chk(16'(n >= 97 && n < 400), 16'h0001);
      go(2);
      #1 chk(usb_ilim_ma_out, 16'h05DC);
      chk(detect_attach_out, 1'b0);
      $display("test default detection done");
      go(1);
      host_mode_in <= 1;
      usb_above_uvlo_in <= 0;
      go(6);
      usb_above_uvlo_in <= 1;
      go(8);
      #1 chk(detect_busy_out, 1'b0);
      answer <= 0;
      force_det();
      #1 chk(detect_force_out, 1'b1);
      wait_idle(n);
      chk(16'(n > 390 && n < 410), 16'h0001);
      go(2);
      #1 chk(usb_ilim_ma_out, 16'h0064);
      chk(detect_force_out, 1'b0);
      answer <= 1;
      force_det();
      go(30);
      host_write_reg2_in <= 1;
      go(1);
      host_write_reg2_in <= 0;
      go(300);
      #1 chk(detect_busy_out, 1'b0);
      chk(usb_ilim_ma_out, 16'h0064);
      $display("test forced detection done");
      go(1);
      host_mode_in <= 0;
      watchdog_expired_in <= 1;
      go(1);
      watchdog_expired_in <= 0;
      go(8);
      #1 chk(usb_ilim_ma_out, 16'h0064);
      usb_limit_sel_in <= 0;
      go(8);
      #1 chk(usb_ilim_ma_out, 16'h05DC);
      host_write_in <= 1;
      go(1);
      host_write_in <= 0;
      // pin still low: once ignored, the detection limit applies
      go(8);
      #1 chk(usb_ilim_ma_out, 16'h0064);
      host_mode_in <= 1;
      host_usb_ilim_in <= 16'h01F4;
      host_ilim_valid_in <= 1;
      go(1);
      host_ilim_valid_in <= 0;
      go(4);
      #1 chk(usb_ilim_ma_out, 16'h01F4);
      $display("test limit select done");
      go(1);
      chip_disable_n_in <= 1;
      go(6);
      #1 chk(hiz_out, 1'b1);
      chk(charge_enable_out, 1'b0);
      chk(n_rst, 2);
      chk(n_reload, 1);
      chip_disable_n_in <= 0;
      go(6);
      #1 chk(hiz_out, 1'b0);
      ntc_below_warm_in <= 0;
      go(6);
      #1 chk(vreg_target_mv_out, 16'h0FDC);
      chk(ntc_zone_out, ZONE_WARM);
      ntc_below_warm_in <= 1;
      ntc_above_cool_in <= 1;
      go(6);
      #1 chk(ichg_target_ma_out, 16'h01F4);
      chk(ntc_zone_out, ZONE_COOL);
      ntc_above_cold_in <= 1;
      go(6);
      #1 chk(timers_suspend_out, 1'b1);
      chk(ntc_zone_out, ZONE_COLD);
      ntc_above_cool_in <= 0;
      ntc_above_cold_in <= 0;
      ntc_below_hot_in <= 0;
      go(6);
      #1 chk(timers_suspend_out, 1'b1);
      chk(charge_enable_out, 1'b0);
      chk(ntc_zone_out, ZONE_HOT);
      ntc_below_hot_in <= 1;
      $display("test disable and zones done");
      die_over_shutdown_in <= 1;
      pulse_len(n);
      chk(16'(n), 16'h0010);
      chk(fault_bits_out, 3'h2);
      chk(regulator_output_out, 1'b0);
      chk(converter_enable_out, 1'b0);
      die_over_shutdown_in <= 0;
      die_cooled_in <= 1;
      go(8);
      #1 chk(charge_enable_out, 1'b1);
      supply_above_sleep_in <= 0;
      pulse_len(n);
      chk(16'(n), 16'h0010);
      chk(discharge_gate_drive_out, 1'b0);
      chk(battery_fet_on_out, 1'b1);
      chk(fault_bits_out, 3'h1);
      chk(regulator_output_out, 1'b0);
      supply_above_sleep_in <= 1;
      go(8);
      #1 chk(fault_bits_out, 3'h0);
      chk(charge_state_bits_out, 3'h0);
      $display("test thermal and sleep done");
      close_out();
   end
   // run should end near 4 us
   initial begin
      #40000;
      fail_count++;
      close_out();
   end
endmodule : testbench

// ==== verification/usb_port_model.sv ====
// behavioural usb port or adapter seen on the data lines
`timescale 1ns/1ps
module usb_port_model (
   // clock and set-up
   input  wire logic clk_in,
   input  wire logic attach_in,
   input  wire logic is_charger_in,
   input  wire logic answer_in,
   // comparator levels seen by the block
   output logic      contact_out,
   output logic      charger_out,
   output logic      dp_low_out,
   output logic      dm_low_out
);
   int cnt = 0;
   // idle port, transceiver quiet
   assign dp_low_out = 1'b1;
   assign dm_low_out = 1'b1;
   // detached circuitry sees nothing
   always @(posedge clk_in) cnt <= attach_in ? cnt + 1 : 0;
   // a mute port never shows contact
   assign contact_out = answer_in && cnt > 5;
   assign charger_out = contact_out && is_charger_in;
endmodule : usb_port_model
